// ### isd_channel.sv
// Input signal delay and status stage of one binary input channel.
// Assumes a debounced input pin from another domain and an AHB-Lite master.
module isd_channel
  import isd_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic debounced_in,
  output logic func_level,
  output logic func_strobe,
  output logic tx_strobe,
  output logic tx_state,
  output logic irq
);

  // ==========================================================================
  // Register map, one aligned word each.
  // ==========================================================================
  // Configuration: enrolment, simulation enable, status enable, on-change
  // reporting, delay enable, delayed signal select, the two delay units and
  // the connected device type, packed low to high as in the cfg_t struct.
  // Delay counts: deasserting count in the low byte, asserting count above.
  // A written zero count becomes one, so the timer never expires instantly.
  // Channel state: reads give the status object, the synchronised pin and
  // the pending flag; a write sets the simulated level while allowed.
  // Interrupt status: sticky event bits, cleared by writing ones.
  // Interrupt mask: same layout; a set bit lets its event raise irq.
  // Manual control: active flag and manual level; ignored unless enrolled.
  // Status request: a write while the status object exists sends the state.
  // Other offsets read as zero and ignore writes; no access ever waits.
  // ==========================================================================
  // Channel state.
  // ==========================================================================
  // All state of the channel except the tick and the delay stage lives in one struct, registered in one place.
  typedef struct packed {
    logic [1:0] sync;
    cfg_t cfg;
    dly_t dly;
    logic man_active;
    logic man_level;
    logic sim_level;
    logic sim_valid;
    logic stat_obj;
    logic last_state;
    logic [4:0] irq_stat;
    logic [4:0] irq_mask;
    logic wr_pend;
    logic [7:0] ph_addr;
    logic [31:0] rdata;
    logic func_level;
    logic func_strobe;
    logic tx_strobe;
    logic tx_state;
    logic irq;
  } st_t;

  st_t st_q;
  st_t st_d;
  logic tick;
  logic src_level;
  logic dly_out;
  logic dly_pending;
  logic dly_cancel;
  logic dly_fwd;
  logic [4:0] ev;

  // Returns a selection allowed for the device type. Every known device type
  // offers the same three choices under its own names, so only the unused
  // selection code and the unused device code are refused; both fall back to
  // delaying the deasserting signal, which is the safer default for sensors.
  function automatic logic [1:0] legal_sel(input logic [1:0] s, input logic [1:0] d);
    if (s > SEL_BOTH || d > DEV_CARD) begin
      legal_sel = SEL_OFF;
    end else begin
      legal_sel = s;
    end
  endfunction : legal_sel

  // ==========================================================================
  // Submodules.
  // ==========================================================================
  // The millisecond tick is shared by every timer of the channel; it runs
  // free, so a delay may end up to one millisecond short of its nominal time.
  isd_tick u_tick (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .tick(tick)
  );

  // The source is manual control when enrolled and active, else the
  // simulated level while the simulation object is enabled and written, else
  // the synchronised pin. Manual control outranks simulation so that an
  // override on site is never masked by a stale simulated level.
  always_comb begin
    if (st_q.cfg.enroll && st_q.man_active) begin
      src_level = st_q.man_level;
    end else if (st_q.cfg.sim_en && st_q.sim_valid) begin
      src_level = st_q.sim_level;
    end else begin
      src_level = st_q.sync[1];
    end
  end

  // The delay stage sees only the chosen source, so manual and simulated
  // levels are delayed and cancelled exactly like the pin.
  isd_delay u_delay (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .tick(tick),
    .level(src_level),
    .dly_en(st_q.cfg.dly_en),
    .sel(st_q.cfg.sel),
    .unit_off(st_q.cfg.unit_off),
    .unit_on(st_q.cfg.unit_on),
    .cnt_off(st_q.dly.off_cnt),
    .cnt_on(st_q.dly.on_cnt),
    .out_level(dly_out),
    .pending(dly_pending),
    .cancel(dly_cancel),
    .fwd(dly_fwd)
  );

  // ==========================================================================
  // Next state.
  // ==========================================================================
  always_comb begin
    st_d = st_q;
    ev = 5'h0;
    // Two flip-flops bring the pin into the clock domain; only the second
    // one is read anywhere else.
    st_d.sync = {st_q.sync[0], debounced_in};
    st_d.func_strobe = dly_fwd;
    st_d.func_level = dly_out;
    st_d.tx_strobe = 1'b0;
    ev[IRQ_CANCEL] = dly_cancel;
    ev[IRQ_FWD] = dly_fwd;

    // ========================================================================
    // Status object.
    // ========================================================================
    // The stored object follows the channel state even while the object is
    // disabled, so enabling it later never exposes a stale value; the telegram
    // depends on the enable and on the reporting mode, the read on the enable.
    if (dly_out != st_q.last_state) begin
      st_d.last_state = dly_out;
      st_d.stat_obj = dly_out;
      ev[IRQ_CHANGE] = 1'b1;
      if (st_q.cfg.stat_en) begin
        if (st_q.cfg.on_change) begin
          st_d.tx_strobe = 1'b1;
          st_d.tx_state = dly_out;
          ev[IRQ_SEND] = 1'b1;
        end
      end
    end

    // ========================================================================
    // Register writes.
    // ========================================================================
    // The data phase of a write takes hwdata; writes are never stalled, so
    // every write lands at the edge that ends its data phase.
    if (st_q.wr_pend) begin
      st_d.wr_pend = 1'b0;
      case (st_q.ph_addr)
        OFS_CFG: begin
          st_d.cfg = cfg_t'(hwdata[12:0]);
          st_d.cfg.sel = legal_sel(hwdata[CFG_SEL_LO +: 2],
                                   hwdata[CFG_DEVTYPE_LO +: 2]);
          // Clearing the simulation enable also drops the simulated level, so
          // the pin takes over again at once.
          if (!hwdata[CFG_SIM_EN]) begin
            st_d.sim_valid = 1'b0;
          end
        end
        OFS_DLY: begin
          st_d.dly.off_cnt = clamp_cnt(hwdata[DLY_OFF_LO +: 8]);
          st_d.dly.on_cnt = clamp_cnt(hwdata[DLY_ON_LO +: 8]);
        end
        OFS_STATE: begin
          if (st_q.cfg.sim_en) begin
            st_d.sim_level = hwdata[0];
            st_d.sim_valid = 1'b1;
          end
        end
        OFS_IRQ_STAT: begin
          // Writing a one clears a bit; events of this cycle are merged later.
          st_d.irq_stat = st_q.irq_stat & ~hwdata[4:0];
        end
        OFS_IRQ_MASK: begin
          st_d.irq_mask = hwdata[4:0];
        end
        OFS_MANUAL: begin
          // Stored always, applied only while enrolled, so enrolment can be
          // toggled without rewriting the manual level.
          st_d.man_active = hwdata[0];
          st_d.man_level = hwdata[1];
        end
        OFS_REQ: begin
          // The answer carries the current state, not the stored object, so
          // it is right even in the cycle in which the state moves.
          if (st_q.cfg.stat_en) begin
            st_d.tx_strobe = 1'b1;
            st_d.tx_state = dly_out;
            ev[IRQ_ANSWER] = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    // ========================================================================
    // Register reads.
    // ========================================================================
    // Address phase decode; read data is prepared for the data phase. The
    // registers are read from the next state, after the write above, so a
    // read that follows a write back to back already sees the written value.
    // The pin and the pending flag come from their own flip-flops.
    if (hsel && hready && htrans[1]) begin
      st_d.ph_addr = haddr[7:0];
      st_d.wr_pend = hwrite;
      case (haddr[7:0])
        OFS_CFG: begin
          st_d.rdata = {19'h0, st_d.cfg};
        end
        OFS_DLY: begin
          st_d.rdata = {16'h0, st_d.dly};
        end
        OFS_STATE: begin
          st_d.rdata = {29'h0, dly_pending, st_q.sync[1],
                        st_d.cfg.stat_en & st_d.stat_obj};
        end
        OFS_IRQ_STAT: begin
          st_d.rdata = {27'h0, st_d.irq_stat};
        end
        OFS_IRQ_MASK: begin
          st_d.rdata = {27'h0, st_d.irq_mask};
        end
        OFS_MANUAL: begin
          st_d.rdata = {30'h0, st_d.man_level, st_d.man_active};
        end
        default: begin
          st_d.rdata = 32'h0;
        end
      endcase
    end

    // ========================================================================
    // Interrupts.
    // ========================================================================
    // Set wins over a clear in the same cycle, so an event that lands on the
    // clearing write is never lost. The line is computed from the next state
    // so that irq leaves its flip-flop in step with the status bits.
    st_d.irq_stat = st_d.irq_stat | ev;
    st_d.irq = |(st_d.irq_stat & st_d.irq_mask);
  end

  // ==========================================================================
  // State register.
  // ==========================================================================
  // Reset loads constants only; clk_en low freezes every bit of state,
  // strobes included, so a strobe stretches while the enable is low.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= '0;
      st_q.cfg <= cfg_t'(CFG_RST[12:0]);
      st_q.dly <= {DLY_CNT_RST, DLY_CNT_RST};
      st_q.irq_mask <= IRQ_MASK_RST;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // Outputs.
  // ==========================================================================
  // Every output leaves a flip-flop, except the bus answer, which is constant
  // because the slave never waits and never signals an error.
  assign hrdata = st_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign func_level = st_q.func_level;
  assign func_strobe = st_q.func_strobe;
  assign tx_strobe = st_q.tx_strobe;
  assign tx_state = st_q.tx_state;
  assign irq = st_q.irq;

endmodule : isd_channel

// ### isd_pkg.sv
// Package for the input signal delay and status stage.
// Assumes a 100 MHz hclk and an AHB-Lite master with single word transfers.
package isd_pkg;

  // ==========================================================================
  // Timing.
  // ==========================================================================
  localparam int unsigned CLK_HZ = 100000000;
  localparam int unsigned MS_PER_S = 1000;
  // One millisecond tick, in clock cycles.
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYC = CLK_HZ / MS_PER_S * TICK_MS;
  localparam int unsigned SEC_MS = 1000;
  localparam int unsigned MIN_MS = 60000;
  localparam int unsigned HOUR_MS = 3600000;

  // ==========================================================================
  // Register byte offsets.
  // ==========================================================================
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_DLY = 8'h04;
  localparam logic [7:0] OFS_STATE = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFS_MANUAL = 8'h14;
  localparam logic [7:0] OFS_REQ = 8'h18;

  // Configuration field positions.
  localparam int unsigned CFG_ENROLL = 0;
  localparam int unsigned CFG_SIM_EN = 1;
  localparam int unsigned CFG_STAT_EN = 2;
  localparam int unsigned CFG_ON_CHANGE = 3;
  localparam int unsigned CFG_DLY_EN = 4;
  localparam int unsigned CFG_SEL_LO = 5;
  localparam int unsigned CFG_UNIT_OFF_LO = 7;
  localparam int unsigned CFG_UNIT_ON_LO = 9;
  localparam int unsigned CFG_DEVTYPE_LO = 11;
  // Delay count field positions.
  localparam int unsigned DLY_OFF_LO = 0;
  localparam int unsigned DLY_ON_LO = 8;

  // Reset values.
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [7:0] DLY_CNT_RST = 8'h05;
  localparam logic [7:0] DLY_CNT_MIN = 8'h01;
  localparam logic [4:0] IRQ_MASK_RST = 5'h00;

  // Interrupt status bit positions.
  localparam int unsigned IRQ_CHANGE = 0;
  localparam int unsigned IRQ_SEND = 1;
  localparam int unsigned IRQ_ANSWER = 2;
  localparam int unsigned IRQ_CANCEL = 3;
  localparam int unsigned IRQ_FWD = 4;

  typedef enum logic [1:0] {
    SEL_OFF = 2'h0,
    SEL_ON = 2'h1,
    SEL_BOTH = 2'h2
  } delayed_signal_select_t;

  typedef enum logic [1:0] {
    UNIT_SEC = 2'h0,
    UNIT_MIN = 2'h1,
    UNIT_HOUR = 2'h2
  } delay_unit_t;

  // Connected device type; switches offer every choice.
  typedef enum logic [1:0] {
    DEV_SWITCH = 2'h0,
    DEV_BUTTON = 2'h1,
    DEV_CARD = 2'h2
  } dev_type_t;

  typedef struct packed {
    logic [1:0] dev_type;
    logic [1:0] unit_on;
    logic [1:0] unit_off;
    logic [1:0] sel;
    logic dly_en;
    logic on_change;
    logic stat_en;
    logic sim_en;
    logic enroll;
  } cfg_t;

  typedef struct packed {
    logic [7:0] on_cnt;
    logic [7:0] off_cnt;
  } dly_t;

  // Unit in milliseconds.
  function automatic logic [21:0] unit_ms(input logic [1:0] u);
    case (u)
      UNIT_MIN: unit_ms = 22'(MIN_MS);
      UNIT_HOUR: unit_ms = 22'(HOUR_MS);
      default: unit_ms = 22'(SEC_MS);
    endcase
  endfunction : unit_ms

  // Clamps a delay count to the legal range one to 255.
  function automatic logic [7:0] clamp_cnt(input logic [7:0] c);
    clamp_cnt = (c < DLY_CNT_MIN) ? DLY_CNT_MIN : c;
  endfunction : clamp_cnt

endpackage : isd_pkg

// ### isd_tick.sv
// Millisecond tick generator.
// Assumes hclk at the package rate and a synchronous clock enable.
module isd_tick
  import isd_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  output logic tick
);

  typedef struct packed {
    logic [16:0] cnt;
    logic tick;
  } st_t;

  st_t st_q;
  st_t st_d;

  // ==========================================================================
  // Divider.
  // ==========================================================================
  // A free running divider keeps delay accuracy within one millisecond.
  always_comb begin
    st_d = st_q;
    st_d.tick = 1'b0;
    if (st_q.cnt == 17'(TICK_CYC - 1)) begin
      st_d.cnt = 17'h0;
      st_d.tick = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + 17'h1;
    end
  end

  // State register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= '0;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign tick = st_q.tick;

endmodule : isd_tick

// ### isd_delay.sv
// Signal delay timer for one channel.
// Assumes a one-cycle millisecond tick and a synchronised input level.
module isd_delay
  import isd_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic tick,
  input wire logic level,
  input wire logic dly_en,
  input wire logic [1:0] sel,
  input wire logic [1:0] unit_off,
  input wire logic [1:0] unit_on,
  input wire logic [7:0] cnt_off,
  input wire logic [7:0] cnt_on,
  output logic out_level,
  output logic pending,
  output logic cancel,
  output logic fwd
);

  typedef struct packed {
    logic prev;
    logic out;
    logic busy;
    logic [21:0] ms;
    logic [7:0] units;
    logic [21:0] unit_len;
    logic cancel;
    logic fwd;
  } st_t;

  st_t st_q;
  st_t st_d;
  logic delayed;

  // Whether a transition towards the new level is selected for delay.
  assign delayed = dly_en && ((sel == SEL_BOTH) ||
                   (sel == SEL_ON && level) || (sel == SEL_OFF && !level));

  // ==========================================================================
  // Timer.
  // ==========================================================================
  // Counting milliseconds then units keeps the counters narrow for hours.
  always_comb begin
    st_d = st_q;
    st_d.cancel = 1'b0;
    st_d.fwd = 1'b0;
    st_d.prev = level;
    if (level != st_q.prev) begin
      if (level == st_q.out) begin
        st_d.busy = 1'b0;
        st_d.cancel = st_q.busy;
      end else if (delayed) begin
        st_d.busy = 1'b1;
        st_d.ms = 22'h0;
        st_d.units = 8'h0;
        st_d.unit_len = unit_ms(level ? unit_on : unit_off);
      end else begin
        st_d.busy = 1'b0;
        st_d.out = level;
        st_d.fwd = 1'b1;
      end
    end else if (st_q.busy && tick) begin
      if (st_q.ms == st_q.unit_len - 22'h1) begin
        st_d.ms = 22'h0;
        st_d.units = st_q.units + 8'h1;
        // Count is clamped to 1..255.
        if (st_q.units + 8'h1 == clamp_cnt(level ? cnt_on : cnt_off)) begin
          st_d.busy = 1'b0;
          st_d.out = level;
          st_d.fwd = 1'b1;
        end
      end else begin
        st_d.ms = st_q.ms + 22'h1;
      end
    end
  end

  // State register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= '0;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign out_level = st_q.out;
  assign pending = st_q.busy;
  assign cancel = st_q.cancel;
  assign fwd = st_q.fwd;

endmodule : isd_delay

// ### isd_channel_props.sv
// Checker for the channel stage; it sees only the top module's ports.
// Assumes one clock domain and the asynchronous active-low reset.
module isd_channel_props
  import isd_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic debounced_in,
  input wire logic func_level,
  input wire logic func_strobe,
  input wire logic tx_strobe,
  input wire logic tx_state,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // =====
  // Bus answers: zero wait, always OKAY, data held between address phases.
  chk_ready_high: assert property (hreadyout)
    else $error("Wait state seen.");
  chk_resp_okay: assert property (!hresp)
    else $error("Error response seen.");
  chk_rdata_hold: assert property (!(hsel && hready && htrans[1]) |=> $stable(hrdata))
    else $error("Read data moved without a request.");
  chk_unmapped_zero: assert property (clk_en && hsel && hready && htrans[1] && !hwrite &&
    haddr[7:0] > OFS_REQ |=> hrdata == 32'h0)
    else $error("Unmapped read not zero.");
  // =====
  // Strobes are single pulses, and levels only move with their strobe.
  chk_tx_pulse: assert property (clk_en && tx_strobe |=> !tx_strobe)
    else $error("Telegram strobe too long.");
  chk_fwd_pulse: assert property (clk_en && func_strobe |=> !func_strobe)
    else $error("Forward strobe too long.");
  chk_tx_value: assert property ($changed(tx_state) |-> tx_strobe)
    else $error("Telegram value moved silently.");
  chk_fwd_marked: assert property ($changed(func_level) |-> ##[0:1] func_strobe)
    else $error("Forwarded level moved silently.");
endmodule : isd_channel_props

// ### bus_party.sv
// Model of a party on the building bus: counts telegrams, keeps the last.
// Assumes each telegram strobe lasts one clock.
module bus_party (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic tx_strobe,
  input wire logic tx_state,
  output logic [7:0] tel_count,
  output logic last_tel
);
  timeunit 1ns;
  timeprecision 1ps;
  // =====
  // A request answer counts like any other telegram, so both reach the tally.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tel_count <= 8'h00;
      last_tel <= 1'b0;
    end else if (tx_strobe) begin
      tel_count <= tel_count + 8'h01;
      last_tel <= tx_state;
    end
  end
endmodule : bus_party

// ### tb_top.sv
// Testbench for the channel stage: bus tasks, queued notes, one monitor.
// Assumes the zero-wait AHB-Lite slave and a 100 MHz clock.
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top
  import isd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // =====
  // Stimulus and observation signals.
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic clk_en = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic debounced_in = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, exp_r, rv;
  logic hreadyout, hresp, func_level, func_strobe, tx_strobe, tx_state, irq, e1, dp_rd;
  logic [7:0] tel_count;
  logic last_tel;
  wire logic hready;
  int err_count = 0;
  int total_checks = 0;
  logic [31:0] rdq[$];
  logic txq[$];
  logic fq[$];
  assign hready = hreadyout;
  always #5 hclk = ~hclk;
  isd_channel dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .debounced_in(debounced_in), .func_level(func_level), .func_strobe(func_strobe),
    .tx_strobe(tx_strobe), .tx_state(tx_state), .irq(irq));
  bus_party party (.hclk(hclk), .hresetn(hresetn), .tx_strobe(tx_strobe),
    .tx_state(tx_state), .tel_count(tel_count), .last_tel(last_tel));
  // =====
  // One bus transfer; the master waits for hready at each phase, and only
  // the watchdog ends a wait that never finishes.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  // The note goes in before the request, so the monitor always finds it.
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rdq.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask : rd
  // Moves the pin; a forwarded level is noted first, a held one is not.
  task automatic pin(input logic v, input logic fwd, input logic tx);
    if (fwd) fq.push_back(v);
    if (tx) txq.push_back(v);
    @(posedge hclk);
    debounced_in <= v;
    repeat (20) @(posedge hclk);
  endtask : pin
  task automatic test_done();
    if (err_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done
  // =====
  // Monitor: any result with no note left is compared against unknown, so it fails.
  always @(posedge hclk) begin
    if (dp_rd === 1'b1 && hready === 1'b1) begin
      exp_r = rdq.size() ? rdq.pop_front() : 32'hx;
      `CHK(hrdata, exp_r)
    end
    dp_rd <= hsel && htrans[1] && !hwrite && hready;
    if (tx_strobe !== 1'b0) begin
      e1 = txq.size() ? txq.pop_front() : 1'bx;
      `CHK(tx_state, e1)
    end
    if (func_strobe !== 1'b0) begin
      e1 = fq.size() ? fq.pop_front() : 1'bx;
      `CHK(func_level, e1)
    end
  end
  initial begin
    #200us;
    err_count++;
    test_done();
  end
  // =====
  // Main sequence.
  initial begin
    void'($urandom(60266));
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rd(OFS_CFG, 32'h0);
    rd(OFS_DLY, 32'h0505);
    rd(OFS_IRQ_MASK, 32'h0);
    rd(8'h1c, 32'h0);
    wr(OFS_DLY, 32'h0);
    rd(OFS_DLY, 32'h0101);
    repeat (3) begin
      rv = $urandom;
      wr(OFS_DLY, rv);
      rd(OFS_DLY, {16'h0, (rv[15:8] == 8'h0) ? 8'h01 : rv[15:8],
        (rv[7:0] == 8'h0) ? 8'h01 : rv[7:0]});
    end
    wr(OFS_CFG, 32'h60);
    rd(OFS_CFG, 32'h0);
    wr(OFS_CFG, 32'h4);
    pin(1'b1, 1'b1, 1'b0);
    rd(OFS_STATE, 32'h3);
    txq.push_back(1'b1);
    wr(OFS_REQ, 32'h1);
    wr(OFS_CFG, 32'hc);
    pin(1'b0, 1'b1, 1'b1);
    wr(OFS_CFG, 32'h8);
    pin(1'b1, 1'b1, 1'b0);
    wr(OFS_REQ, 32'h1);
    rd(OFS_STATE, 32'h2);
    wr(OFS_MANUAL, 32'h1);
    repeat (10) @(posedge hclk);
    fq.push_back(1'b0);
    wr(OFS_CFG, 32'h9);
    repeat (10) @(posedge hclk);
    fq.push_back(1'b1);
    wr(OFS_MANUAL, 32'h0);
    wr(OFS_CFG, 32'h0);
    wr(OFS_STATE, 32'h0);
    repeat (10) @(posedge hclk);
    wr(OFS_CFG, 32'h2);
    fq.push_back(1'b0);
    wr(OFS_STATE, 32'h0);
    repeat (10) @(posedge hclk);
    fq.push_back(1'b1);
    wr(OFS_STATE, 32'h1);
    repeat (10) @(posedge hclk);
    wr(OFS_IRQ_STAT, 32'h1f);
    wr(OFS_IRQ_MASK, 32'h8);
    wr(OFS_CFG, 32'h4d0);
    rd(OFS_CFG, 32'h4d0);
    pin(1'b0, 1'b0, 1'b0);
    rd(OFS_STATE, 32'h4);
    `CHK(irq, 1'b0)
    pin(1'b1, 1'b0, 1'b0);
    `CHK(irq, 1'b1)
    wr(OFS_IRQ_MASK, 32'h0);
    repeat (3) @(posedge hclk);
    `CHK(irq, 1'b0)
    wr(OFS_IRQ_STAT, 32'h8);
    wr(OFS_IRQ_MASK, 32'h8);
    repeat (3) @(posedge hclk);
    `CHK(irq, 1'b0)
    wr(OFS_CFG, 32'h30);
    pin(1'b0, 1'b1, 1'b0);
    pin(1'b1, 1'b0, 1'b0);
    rd(OFS_STATE, 32'h6);
    pin(1'b0, 1'b0, 1'b0);
    `CHK(irq, 1'b1)
    // A frozen clock enable holds the pin change back until it is raised.
    wr(OFS_CFG, 32'h0);
    @(posedge hclk);
    clk_en <= 1'b0;
    pin(1'b1, 1'b1, 1'b0);
    `CHK(func_level, 1'b0)
    clk_en <= 1'b1;
    repeat (10) @(posedge hclk);
    `CHK(tel_count, 8'h02)
    `CHK(last_tel, 1'b0)
    `CHK(rdq.size() + txq.size() + fq.size(), 0)
    test_done();
  end
endmodule : tb_top
bind isd_channel isd_channel_props chk (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
  .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .debounced_in(debounced_in), .func_level(func_level),
  .func_strobe(func_strobe), .tx_strobe(tx_strobe), .tx_state(tx_state), .irq(irq));
